// file: src/tlq_cfg.svh
// Constants for the trace, loopback and QoS-accept sideband responder.
// Assumes inclusion by bare name from the design file; the package does not include it.
`ifndef TLQ_CFG_SVH
`define TLQ_CFG_SVH

// APB register byte offsets
`define TLQ_OFF_CTRL      12'h000
`define TLQ_OFF_QOS       12'h004
`define TLQ_OFF_STATUS    12'h008
`define TLQ_OFF_COUNT     12'h00c

// Control field positions
`define TLQ_CTRL_TRACE_EN 0
`define TLQ_CTRL_SPAWN_EN 1
`define TLQ_CTRL_UNSOL    2
`define TLQ_CTRL_SWAP_EN  3
`define TLQ_CTRL_SPLIT    4

// Reset values and starvation limit
`define TLQ_CTRL_RST      5'h03
`define TLQ_QOS_RST       4'h0
`define TLQ_STARVE_NS     1000
`define TLQ_STARVE_CYC    ((`TLQ_STARVE_NS * 125) / 1000)

`endif

// file: src/tlq_pkg.sv
// Types for the trace, loopback and QoS-accept sideband responder.
// Assumes tlq_cfg.svh is on the include path.
package tlq_pkg;

    // Pending write response beat kind
    typedef enum logic [1:0] {TLQ_B_COMBINED, TLQ_B_COMP, TLQ_B_PERSIST} tlq_bkind_e;

    // Request sideband as taken at a handshake
    typedef struct packed {
        logic       trace;
        logic [7:0] loop;
        logic [3:0] qos;
        logic       pcmo;
        logic       atomic;
    } tlq_req_s;

    // Response sideband
    typedef struct packed {
        logic       trace;
        logic [7:0] loop;
        logic       comp;
        logic       persist;
    } tlq_rsp_s;

endpackage : tlq_pkg

// file: src/tlq_sideband.sv
// Responder-side sideband logic for trace flags, loopback tags and QoS acceptance.
// Assumes a single pclk domain; request and response channels come from logic on
// pclk; registers are reached over APB.
//
// Functional notes
// - Combined persist response sets both completion and persist flags
// - Completion flag on exactly one beat
// - Every present channel carries trace
// - Traced request gets traced response
// - Same-address spawned snoop inherits trace
// - Unrequested trace allowed on some responses
// - Never depend on trace propagation
// - Traced write address traces write response; the split persist-only beat has b_trace cleared
// - Write data trace forwarded; atomic read follows
// - Traced read traces every data beat
// - Four loopback buses, configurable width
// - Read loopback equals read address tag
// - Write loopback equals write address tag
// - Persist-only response loopback arbitrary
// - Atomic read loopback equals write tag
// - Tags need not be unique
// - Own tag downstream, restore upstream
// - Snoop channels carry no loopback
// - Two 4-bit acceptance levels, accept at/above
// - Below-level stalled, never forever
// - Acceptance outputs synchronous, default zero
`timescale 1ns/1ps
`include "tlq_cfg.svh"

module tlq_sideband #(
    parameter int LB        = 8,
    parameter int DEPTH     = 4,
    parameter int STARVE    = `TLQ_STARVE_CYC
) (
    // Clock and reset
    input  wire logic                pclk,
    input  wire logic                presetn,
    // APB slave
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [11:0]         paddr,
    input  wire logic [31:0]         pwdata,
    output logic                     pready,
    output logic                     pslverr,
    output logic [31:0]              prdata,
    // Upstream read address
    input  wire logic                ar_valid,
    output logic                     ar_ready,
    input  wire logic                ar_trace,
    input  wire logic [LB-1:0]       ar_loop,
    input  wire logic [3:0]          ar_qos,
    // Upstream read data
    output logic                     r_valid,
    input  wire logic                r_ready,
    output logic                     r_last,
    output logic                     r_trace,
    output logic [LB-1:0]            r_loop,
    // Upstream write address
    input  wire logic                aw_valid,
    output logic                     aw_ready,
    input  wire logic                aw_trace,
    input  wire logic [LB-1:0]       aw_loop,
    input  wire logic [3:0]          aw_qos,
    input  wire logic                aw_pcmo,
    input  wire logic                aw_atomic,
    // Upstream write data
    input  wire logic                w_valid,
    output logic                     w_ready,
    input  wire logic                w_trace,
    input  wire logic                w_last,
    // Upstream write response
    output logic                     b_valid,
    input  wire logic                b_ready,
    output logic                     b_trace,
    output logic [LB-1:0]            b_loop,
    output logic                     b_comp,
    output logic                     b_persist,
    // Downstream write data trace and spawned snoop
    output logic                     dw_trace,
    output logic                     ac_valid,
    input  wire logic                ac_ready,
    output logic                     ac_trace,
    input  wire logic                cr_valid,
    input  wire logic                cr_trace,
    // Acceptance levels
    output logic [3:0]               ar_qos_accept,
    output logic [3:0]               aw_qos_accept
);

    localparam int IW = $clog2(DEPTH);

    // ****************************************************************
    // Registers and state
    // ****************************************************************
    logic [4:0]          ctrl;
    logic [3:0]          rd_level;
    logic [3:0]          wr_level;
    logic [15:0]         trace_count;
    logic                r_busy;
    logic [3:0]          r_beats;
    logic                b_busy;
    tlq_pkg::tlq_bkind_e b_kind;
    logic                b_persist_due;
    logic [LB-1:0]       tag_store [DEPTH];
    logic                tag_trace [DEPTH];
    logic [IW-1:0]       tag_wr;
    logic [IW-1:0]       tag_rd;
    logic [15:0]         rd_wait;
    logic [15:0]         wr_wait;
    logic                w_seen;

    // Priority admission: at or above level, or waited long enough
    function automatic logic admit(input logic [3:0] qos, input logic [3:0] lvl,
                                   input logic [15:0] waited);
        admit = (qos >= lvl) || (waited >= 16'(STARVE));
    endfunction : admit

    wire ar_hs = ar_valid && ar_ready;
    wire aw_hs = aw_valid && aw_ready;
    wire r_hs  = r_valid && r_ready;
    wire b_hs  = b_valid && b_ready;
    wire apb_wr = psel && penable && pwrite;
    // Atomic writes wait while a read is pending so the two never share the read channel
    wire aw_take = !b_busy && !aw_hs && aw_valid && !(aw_atomic && (r_busy || ar_valid))
                   && admit(aw_qos, wr_level, wr_wait);

    // ****************************************************************
    // APB slave
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl     <= `TLQ_CTRL_RST;
            rd_level <= `TLQ_QOS_RST;
            wr_level <= `TLQ_QOS_RST;
        end
        else if (apb_wr && paddr == `TLQ_OFF_CTRL)
            ctrl <= pwdata[4:0];
        else if (apb_wr && paddr == `TLQ_OFF_QOS)
        begin
            rd_level <= pwdata[3:0];
            wr_level <= pwdata[7:4];
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end
        else
        begin
            pready  <= psel && !penable;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
            if (psel && !penable)
            begin
                unique case (paddr)
                    `TLQ_OFF_CTRL:   prdata <= {27'h0, ctrl};
                    `TLQ_OFF_QOS:    prdata <= {24'h0, wr_level, rd_level};
                    `TLQ_OFF_STATUS: prdata <= {28'h0, b_persist_due, b_busy, r_busy, w_seen};
                    `TLQ_OFF_COUNT:  prdata <= {16'h0, trace_count};
                    default:         pslverr <= !pwrite;
                endcase
            end
        end
    end

    // ****************************************************************
    // Acceptance levels
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ar_qos_accept <= `TLQ_QOS_RST;
            aw_qos_accept <= `TLQ_QOS_RST;
        end
        else
        begin
            ar_qos_accept <= rd_level;
            aw_qos_accept <= wr_level;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rd_wait <= 16'h0000;
            wr_wait <= 16'h0000;
        end
        else
        begin
            rd_wait <= (ar_valid && !ar_hs && rd_wait != 16'hffff) ? rd_wait + 16'h0001 : 16'h0000;
            wr_wait <= (aw_valid && !aw_hs && wr_wait != 16'hffff) ? wr_wait + 16'h0001 : 16'h0000;
        end
    end

    // ****************************************************************
    // Read path: tag and trace returned on every beat
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ar_ready <= 1'b0;
            r_busy   <= 1'b0;
            r_valid  <= 1'b0;
            r_last   <= 1'b0;
            r_trace  <= 1'b0;
            r_loop   <= '0;
            r_beats  <= 4'h0;
        end
        else
        begin
            ar_ready <= !r_busy && !ar_hs && ar_valid && !(aw_hs && aw_atomic)
                        && admit(ar_qos, rd_level, rd_wait);
            if (ar_hs)
            begin
                r_busy  <= 1'b1;
                r_valid <= 1'b1;
                r_beats <= 4'h3;
                r_last  <= 1'b0;
                r_loop  <= ar_loop;
                r_trace <= (ar_trace && ctrl[`TLQ_CTRL_TRACE_EN])
                           || ctrl[`TLQ_CTRL_UNSOL];
            end
            else if (aw_hs && aw_atomic && !r_busy)
            begin
                r_busy  <= 1'b1;
                r_valid <= 1'b1;
                r_beats <= 4'h0;
                r_last  <= 1'b1;
                r_loop  <= aw_loop;
                r_trace <= aw_trace && ctrl[`TLQ_CTRL_TRACE_EN];
            end
            else if (r_hs)
            begin
                if (r_last)
                begin
                    r_busy  <= 1'b0;
                    r_valid <= 1'b0;
                    r_last  <= 1'b0;
                end
                else
                begin
                    r_beats <= r_beats - 4'h1;
                    r_last  <= (r_beats == 4'h1);
                end
            end
        end
    end

    // ****************************************************************
    // Write path with tag substitution store
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            aw_ready <= 1'b0;
            w_ready  <= 1'b0;
            w_seen   <= 1'b0;
            dw_trace <= 1'b0;
            tag_wr   <= '0;
            for (int i = 0; i < DEPTH; i++)
            begin
                tag_store[i] <= '0;
                tag_trace[i] <= 1'b0;
            end
        end
        else
        begin
            aw_ready <= aw_take;
            w_ready  <= 1'b1;
            if (w_valid && w_ready)
            begin
                dw_trace <= w_trace;
                w_seen   <= !w_last;
            end
            // Stored one cycle before the handshake so the response can restore it
            if (aw_take)
            begin
                tag_store[tag_wr] <= aw_loop;
                tag_trace[tag_wr] <= aw_trace;
                tag_wr            <= tag_wr + 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            b_busy        <= 1'b0;
            b_valid       <= 1'b0;
            b_trace       <= 1'b0;
            b_loop        <= '0;
            b_comp        <= 1'b0;
            b_persist     <= 1'b0;
            b_kind        <= tlq_pkg::TLQ_B_COMBINED;
            b_persist_due <= 1'b0;
            tag_rd        <= '0;
        end
        else if (aw_hs)
        begin
            b_busy        <= 1'b1;
            b_valid       <= 1'b1;
            b_loop        <= ctrl[`TLQ_CTRL_SWAP_EN] ? tag_store[tag_rd] : aw_loop;
            b_trace       <= (ctrl[`TLQ_CTRL_SWAP_EN] ? tag_trace[tag_rd] : aw_trace)
                             && ctrl[`TLQ_CTRL_TRACE_EN];
            b_comp        <= 1'b1;
            b_persist     <= aw_pcmo && !ctrl[`TLQ_CTRL_SPLIT];
            b_kind        <= (aw_pcmo && ctrl[`TLQ_CTRL_SPLIT]) ? tlq_pkg::TLQ_B_COMP
                                                               : tlq_pkg::TLQ_B_COMBINED;
            b_persist_due <= aw_pcmo && ctrl[`TLQ_CTRL_SPLIT];
            tag_rd        <= tag_rd + 1'b1;
        end
        else if (b_hs)
        begin
            if (b_persist_due && b_kind == tlq_pkg::TLQ_B_COMP)
            begin
                b_kind        <= tlq_pkg::TLQ_B_PERSIST;
                b_comp        <= 1'b0;
                b_persist     <= 1'b1;
                b_loop        <= '0;
                b_trace       <= 1'b0;
                b_persist_due <= 1'b0;
            end
            else
            begin
                b_busy    <= 1'b0;
                b_valid   <= 1'b0;
                b_comp    <= 1'b0;
                b_persist <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // Spawned same-address snoop and trace counter
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ac_valid <= 1'b0;
            ac_trace <= 1'b0;
        end
        else if (aw_hs && aw_pcmo && !ac_valid)
        begin
            ac_valid <= 1'b1;
            ac_trace <= aw_trace && ctrl[`TLQ_CTRL_SPAWN_EN];
        end
        else if (ac_valid && ac_ready)
            ac_valid <= 1'b0;
    end

    // Counts traced snoop responses; nothing here waits on them
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            trace_count <= 16'h0000;
        else if (apb_wr && paddr == `TLQ_OFF_COUNT)
            trace_count <= (cr_valid && cr_trace) ? 16'h0001 : 16'h0000;
        else if (cr_valid && cr_trace)
            trace_count <= trace_count + 16'h0001;
    end

endmodule : tlq_sideband

// file: verification/tlq_sideband_asserts.sv
// Checker of tag echo, trace echo and acceptance timing of the responder.
// Assumes it is bound into tlq_sideband and receives its LB parameter.
`timescale 1ns/1ps
module tlq_sideband_asserts #(
    parameter int LB = 8
) (
    // Clock and reset
    input wire logic          pclk,
    input wire logic          presetn,
    // Read channels
    input wire logic          ar_valid,
    input wire logic          ar_ready,
    input wire logic          ar_trace,
    input wire logic [LB-1:0] ar_loop,
    input wire logic [3:0]    ar_qos,
    input wire logic          r_valid,
    input wire logic          r_trace,
    input wire logic [LB-1:0] r_loop,
    // Write channels
    input wire logic          aw_valid,
    input wire logic          aw_ready,
    input wire logic          aw_trace,
    input wire logic [LB-1:0] aw_loop,
    input wire logic          aw_atomic,
    input wire logic          b_valid,
    input wire logic          b_ready,
    input wire logic          b_trace,
    input wire logic [LB-1:0] b_loop,
    input wire logic          b_comp,
    // Acceptance levels
    input wire logic [3:0]    ar_qos_accept,
    input wire logic [3:0]    aw_qos_accept
);
    logic [LB-1:0] rd_tag, wr_tag;
    logic          rd_tr, wr_tr;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    sequence aw_hs;
        aw_valid && aw_ready;
    endsequence
    sequence rd_fit;
        $rose(ar_valid) && ar_qos >= ar_qos_accept && !r_valid;
    endsequence
    // Tags to echo; the read data of an atomic echoes the write tag
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
            {rd_tag, rd_tr, wr_tag, wr_tr} <= '0;
        else if (aw_valid && aw_ready && aw_atomic)
            {rd_tag, rd_tr, wr_tag, wr_tr} <= {2{aw_loop, aw_trace}};
        else if (aw_valid && aw_ready)
            {wr_tag, wr_tr} <= {aw_loop, aw_trace};
        else if (ar_valid && ar_ready)
            {rd_tag, rd_tr} <= {ar_loop, ar_trace};
    qos_reset_zero_a:
        assert property ($rose(presetn) |-> {ar_qos_accept, aw_qos_accept} == 8'h00)
        else $error("acceptance level not zero");
    rd_tag_echo_a:
        assert property (r_valid |-> r_loop == rd_tag)
        else $error("read tag differs");
    rd_trace_echo_a:
        assert property (r_valid && rd_tr |-> r_trace)
        else $error("read trace missing");
    wr_tag_echo_a:
        assert property (b_valid && b_comp |-> b_loop == wr_tag)
        else $error("write tag differs");
    wr_trace_echo_a:
        assert property (b_valid && b_comp && wr_tr |-> b_trace)
        else $error("write trace missing");
    comp_after_aw_a:
        assert property (aw_hs |=> b_valid && b_comp)
        else $error("no completion beat");
    comp_once_a:
        assert property (b_valid && b_ready && b_comp |=> !(b_valid && b_comp))
        else $error("second completion beat");
    rd_accept_a:
        assert property (rd_fit |-> ##[1:3] ar_ready)
        else $error("read at level not accepted");
endmodule : tlq_sideband_asserts

bind tlq_sideband tlq_sideband_asserts #(.LB(LB)) u_tlq_sideband_asserts (
    .pclk, .presetn, .ar_valid, .ar_ready, .ar_trace, .ar_loop, .ar_qos, .r_valid, .r_trace,
    .r_loop, .aw_valid, .aw_ready, .aw_trace, .aw_loop, .aw_atomic, .b_valid, .b_ready,
    .b_trace, .b_loop, .b_comp, .ar_qos_accept, .aw_qos_accept
);

// file: verification/tlq_master_model.sv
// Model of the requesting master: response readies and snoop answers.
// Assumes the pclk domain of the responder.
`timescale 1ns/1ps
module tlq_master_model (
    // Clock, reset and stall control
    input wire logic pclk,
    input wire logic presetn,
    input wire logic slow,
    // Snoop from the responder
    input wire logic ac_valid,
    input wire logic ac_trace,
    // Answers to the responder
    output logic     r_ready,
    output logic     b_ready,
    output logic     ac_ready,
    output logic     cr_valid,
    output logic     cr_trace
);
    logic tick;
    // Readies stall every other cycle when slow
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
            {tick, r_ready, b_ready, ac_ready} <= '0;
        else
            {tick, r_ready, b_ready, ac_ready} <= {~tick, {3{~slow | tick}}};
    // Snoop answer echoes its trace and carries no tag
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
            {cr_valid, cr_trace} <= '0;
        else if (ac_valid && ac_ready)
            {cr_valid, cr_trace} <= {1'h1, ac_trace};
        else
            {cr_valid, cr_trace} <= {1'h0, ~cr_trace};
endmodule : tlq_master_model

// file: verification/tlq_sideband_tb.sv
// Bench of the responder: registers, reads, writes, atomics, persist operations.
// Assumes the design, its checker and tlq_master_model are compiled first.
`timescale 1ns/1ps
module tlq_sideband_tb;
    localparam int STARVE = 4;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, slow, perr;
    logic        ar_valid, ar_ready, ar_trace, r_valid, r_ready, r_last, r_trace;
    logic        aw_valid, aw_ready, aw_trace, aw_pcmo, aw_atomic, w_valid, w_ready;
    logic        w_trace, w_last, b_valid, b_ready, b_trace, b_comp, b_persist;
    logic        dw_trace, ac_valid, ac_ready, ac_trace, cr_valid, cr_trace;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [7:0]  ar_loop, r_loop, aw_loop, b_loop;
    logic [3:0]  ar_qos, aw_qos, ar_qos_accept, aw_qos_accept;
    int          n_mismatch = 0, comparisons = 0, waited;
    tlq_sideband #(.STARVE(STARVE)) u_tlq_sideband (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr, .prdata,
        .ar_valid, .ar_ready, .ar_trace, .ar_loop, .ar_qos, .r_valid, .r_ready, .r_last,
        .r_trace, .r_loop, .aw_valid, .aw_ready, .aw_trace, .aw_loop, .aw_qos, .aw_pcmo,
        .aw_atomic, .w_valid, .w_ready, .w_trace, .w_last, .b_valid, .b_ready, .b_trace,
        .b_loop, .b_comp, .b_persist, .dw_trace, .ac_valid, .ac_ready, .ac_trace,
        .cr_valid, .cr_trace, .ar_qos_accept, .aw_qos_accept);
    tlq_master_model u_tlq_master_model (.pclk, .presetn, .slow, .ac_valid, .ac_trace,
        .r_ready, .b_ready, .ac_ready, .cr_valid, .cr_trace);
    initial
    begin
        pclk = 1'h0;
        forever #4 pclk = ~pclk;
    end
    task automatic chk(input string what, input logic [31:0] exp, got);
        comparisons++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic finish_test;
        if (n_mismatch == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : finish_test
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'h2, wr, a, d};
        @(posedge pclk);
        penable <= 1'h1;
        do @(posedge pclk); while (pready !== 1'h1);
        {perr, rd} = {pslverr, prdata};
        {psel, penable} <= 2'h0;
    endtask : apb
    task automatic ar_send(input logic [7:0] tag, input logic tr, input logic [3:0] q);
        @(posedge pclk);
        {ar_valid, ar_loop, ar_trace, ar_qos} <= {1'h1, tag, tr, q};
        for (waited = 1; ar_ready !== 1'h1 || waited == 1; waited++)
            @(posedge pclk);
        ar_valid <= 1'h0;
    endtask : ar_send
    task automatic rbeats(input logic [7:0] tag, input logic tr, input int n);
        for (int i = 1; i <= n; i++)
        begin
            do @(posedge pclk); while (!(r_valid === 1'h1 && r_ready === 1'h1));
            chk("r_tag_trace", {tag, tr}, {r_loop, r_trace});
            chk("r_last", i == n, r_last);
        end
    endtask : rbeats
    task automatic aw_send(input logic [7:0] tag, input logic tr, pcmo, atomic);
        @(posedge pclk);
        {w_valid, w_trace, w_last} <= {1'h1, ~tr, 1'h1};
        do @(posedge pclk); while (w_ready !== 1'h1);
        w_valid <= 1'h0;
        {aw_valid, aw_loop, aw_trace, aw_pcmo, aw_atomic} <= {1'h1, tag, tr, pcmo, atomic};
        do @(posedge pclk); while (aw_ready !== 1'h1);
        aw_valid <= 1'h0;
        chk("dw_trace", !tr, dw_trace);
    endtask : aw_send
    task automatic bchk(input logic [7:0] tag, input logic tr, comp, pers);
        do @(posedge pclk); while (!(b_valid === 1'h1 && b_ready === 1'h1));
        chk("b_comp_persist", {comp, pers}, {b_comp, b_persist});
        if (comp)
            chk("b_tag_trace", {tag, tr}, {b_loop, b_trace});
    endtask : bchk
    task automatic t_regs;
        apb(1'h0, 12'h004, 32'h0);
        chk("qos_reg", 32'h0, rd);
        chk("qos_levels", 8'h00, {aw_qos_accept, ar_qos_accept});
        apb(1'h1, 12'h004, 32'h85);
        repeat (2) @(posedge pclk);
        chk("qos_levels", 8'h85, {aw_qos_accept, ar_qos_accept});
        apb(1'h0, 12'h010, 32'h0);
        chk("unmapped_err", 1'h1, perr);
    endtask : t_regs
    task automatic t_reads;
        ar_send(8'h5a, 1'h1, 4'h7);
        rbeats(8'h5a, 1'h1, 4);
        slow <= 1'h1;
        ar_send(8'h5a, 1'h0, 4'h5);
        rbeats(8'h5a, 1'h0, 4);
        slow <= 1'h0;
        ar_send(8'ha5, 1'h1, 4'h2);
        chk("low_prio_wait", 1'h1, waited > STARVE && waited < STARVE + 8);
        rbeats(8'ha5, 1'h1, 4);
    endtask : t_reads
    task automatic t_writes;
        aw_send(8'hc3, 1'h1, 1'h0, 1'h0);
        bchk(8'hc3, 1'h1, 1'h1, 1'h0);
        aw_send(8'h3c, 1'h1, 1'h0, 1'h1);
        fork
            bchk(8'h3c, 1'h1, 1'h1, 1'h0);
            rbeats(8'h3c, 1'h1, 1);
        join
    endtask : t_writes
    task automatic t_pcmo;
        apb(1'h1, 12'h00c, 32'h0);
        aw_send(8'h77, 1'h1, 1'h1, 1'h0);
        bchk(8'h77, 1'h1, 1'h1, 1'h1);
        apb(1'h1, 12'h000, 32'h13);
        aw_send(8'h11, 1'h0, 1'h1, 1'h0);
        bchk(8'h11, 1'h0, 1'h1, 1'h0);
        bchk(8'h11, 1'h0, 1'h0, 1'h1);
        apb(1'h0, 12'h00c, 32'h0);
        chk("snoop_count", 32'h1, rd);
    endtask : t_pcmo
    task automatic t_modes;
        apb(1'h1, 12'h000, 32'h0d);
        apb(1'h0, 12'h000, 32'h0);
        chk("ctrl_reg", 32'h0d, rd);
        ar_send(8'h33, 1'h0, 4'h7);
        rbeats(8'h33, 1'h1, 4);
        aw_send(8'h99, 1'h1, 1'h0, 1'h0);
        bchk(8'h99, 1'h1, 1'h1, 1'h0);
    endtask : t_modes
    initial
    begin
        {psel, penable, pwrite, paddr, pwdata, ar_valid, ar_trace, ar_loop, ar_qos} = '0;
        {aw_valid, aw_trace, aw_loop, aw_pcmo, aw_atomic, w_valid, w_trace, slow} = '0;
        {aw_qos, w_last} = 5'h1f;
        presetn = 1'h0;
        repeat (10) @(posedge pclk);
        presetn <= 1'h1;
        t_regs();
        t_reads();
        t_writes();
        t_pcmo();
        t_modes();
        finish_test();
    end
    initial
    begin
        repeat (5000) @(posedge pclk);
        n_mismatch++;
        finish_test();
    end
endmodule : tlq_sideband_tb
